// >>> include/mmu_pkg.sv
// Shared constants and types for the memory paging unit.
package mmu_pkg;

    // =====================================================================
    // Widths and reset values
    // =====================================================================
    localparam int           PHYS_W       = 17;
    localparam int           CPU_W        = 16;
    localparam int           PAGE_W       = 3;
    localparam int           REGION_OFF_W = 14;
    localparam logic [7:0]   PAGE_RESET   = 8'h02;
    localparam logic [16:0]  PTR_RESET    = 17'h00000;

    // =====================================================================
    // Processor regions (three unpaged, one window), selected by the two top address bits
    // =====================================================================
    localparam logic [1:0]   REGION_RAM   = 2'h0;
    localparam logic [1:0]   REGION_LOW   = 2'h1;
    localparam logic [1:0]   REGION_WIN   = 2'h2;
    localparam logic [1:0]   REGION_HIGH  = 2'h3;
    localparam logic [2:0]   LOW_PAGE     = 3'h1;
    localparam logic [2:0]   HIGH_PAGE    = 3'h3;

    // =====================================================================
    // Pointer steps
    // =====================================================================
    localparam logic [7:0]   STEP_BYTE    = 8'h01;
    localparam logic [7:0]   STEP_WORD    = 8'h02;

    // =====================================================================
    // Register indices on the register port
    // =====================================================================
    typedef enum logic [2:0] {
        REG_PAGE_SELECT  = 3'h0,
        REG_PTR_HIGH     = 3'h1,
        REG_PTR_MID      = 3'h2,
        REG_PTR_LOW      = 3'h3,
        REG_BYTE_DATA    = 3'h4,
        REG_BYTE_AUTOINC = 3'h5,
        REG_WORD_AUTOINC = 3'h6,
        REG_OFFSET_ADD   = 3'h7
    } reg_sel_type;

endpackage

// >>> src/page_decoder.sv
// Translation of a processor address into a physical memory address.
`timescale 1ns/1ps
module page_decoder
    import mmu_pkg::*;
(
    // Processor side
    input  wire logic [CPU_W-1:0]  cpu_addr,
    input  wire logic [PAGE_W-1:0] page,
    // Physical side
    output logic      [PHYS_W-1:0] phys_addr,
    output logic                   ram_sel
);

    // =====================================================================
    // Region decode
    // =====================================================================
    // Each region is 16 KB, so the page number simply sits above the offset.
    always_comb begin
        ram_sel   = 1'b0;
        phys_addr = {LOW_PAGE, cpu_addr[REGION_OFF_W-1:0]};
        unique case (cpu_addr[CPU_W-1 -: 2])
            REGION_RAM: begin
                // RAM wins this range; flash page 0 behind it is reached only linearly or through the window with page 0.
                ram_sel   = 1'b1;
                phys_addr = {3'h0, cpu_addr[REGION_OFF_W-1:0]};
            end
            REGION_LOW: begin
                phys_addr = {LOW_PAGE, cpu_addr[REGION_OFF_W-1:0]};  // see [RL4]
            end
            REGION_WIN: begin
                phys_addr = {page, cpu_addr[REGION_OFF_W-1:0]};  // see [RL1] see [RL3]
            end
            REGION_HIGH: begin
                phys_addr = {HIGH_PAGE, cpu_addr[REGION_OFF_W-1:0]};  // see [RL4]
            end
        endcase
    end

endmodule

// >>> src/pointer_step.sv
// Signed byte step added to the linear pointer with full wrap.
`timescale 1ns/1ps
module pointer_step
    import mmu_pkg::*;
(
    // Operands
    input  wire logic [PHYS_W-1:0] ptr,
    input  wire logic [7:0]        step,
    // Result
    output logic      [PHYS_W-1:0] sum
);

    // =====================================================================
    // Adder
    // =====================================================================
    // Sign extension lets one adder serve increments and negative offsets.
    always_comb begin
        sum = ptr + {{(PHYS_W-8){step[7]}}, step};  // see [RL9] see [RL12]
    end

endmodule

// >>> src/memory_paging_unit.sv
// Memory paging unit: page window, linear pointer and memory routing.
// What this block does
// [RL1] Window 0x8000-0xBFFF shows the selected page.
// [RL2] Page select: eight bits, three-bit page.
// [RL3] Window address is page times size plus offset.
// [RL4] Three unpaged regions: RAM, two flash.
// [RL5] Seventeen-bit pointer held in three byte registers.
// [RL6] Byte data register accesses byte at pointer.
// [RL7] Byte autoincrement accesses then adds one.
// [RL8] Word autoincrement moves two bytes, adds two.
// [RL9] Offset register adds signed byte to pointer.
// [RL10] Page select resets to page two.
// [RL11] Word: lower address byte in upper half.
// [RL12] Pointer arithmetic carries and wraps over 17 bits.
`timescale 1ns/1ps
module memory_paging_unit
    import mmu_pkg::*;
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rstn,
    // Register port
    input  wire logic [2:0]         reg_addr,
    input  wire logic [15:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [15:0]        reg_rdata,
    // Processor memory bus
    input  wire logic [CPU_W-1:0]   core_addr,
    input  wire logic [7:0]         core_wdata,
    input  wire logic               core_wr,
    input  wire logic               core_rd,
    output logic                    core_ready,
    output logic      [7:0]         core_rdata,
    // Physical memory bus
    output logic      [PHYS_W-1:0]  mem_addr,
    output logic                    mem_ram,
    output logic                    mem_wide,
    output logic                    mem_wr,
    output logic                    mem_rd,
    output logic      [15:0]        mem_wdata,
    input  wire logic [15:0]        mem_rdata
);

    // =====================================================================
    // State
    // =====================================================================
    logic [PAGE_W-1:0] page_r, page_nxt;
    logic [PHYS_W-1:0] ptr_r, ptr_nxt;
    logic [15:0]       rdata_r, rdata_nxt;
    logic              mem_byte_r, mem_byte_nxt;
    logic              mem_word_r, mem_word_nxt;

    // =====================================================================
    // Access decode
    // =====================================================================
    reg_sel_type       sel;
    logic              reg_acc;
    logic              lin_acc;
    logic              step_acc;
    logic [7:0]        step;
    logic [PHYS_W-1:0] ptr_sum;
    logic [PHYS_W-1:0] core_phys;
    logic              core_ram;

    // Only the three data registers touch memory through the pointer.
    always_comb begin
        sel      = reg_sel_type'(reg_addr);
        reg_acc  = reg_rd | reg_wr;
        lin_acc  = reg_acc && (sel == REG_BYTE_DATA || sel == REG_BYTE_AUTOINC ||
                               sel == REG_WORD_AUTOINC);
        step_acc = reg_acc && (sel == REG_BYTE_AUTOINC || sel == REG_WORD_AUTOINC);
        if (sel == REG_WORD_AUTOINC) begin
            step = STEP_WORD;  // see [RL8]
        end else if (sel == REG_BYTE_AUTOINC) begin
            step = STEP_BYTE;  // see [RL7]
        end else begin
            step = reg_wdata[7:0];  // see [RL9]
        end
    end

    pointer_step u_step (
        .ptr  (ptr_r),
        .step (step),
        .sum  (ptr_sum)
    );

    page_decoder u_decode (
        .cpu_addr  (core_addr),
        .page      (page_r),
        .phys_addr (core_phys),
        .ram_sel   (core_ram)
    );

    // =====================================================================
    // Memory routing
    // =====================================================================
    // A linear register access owns the memory port for its cycle; the
    // processor bus is held off through core_ready rather than dropped.
    always_comb begin
        core_ready = ~lin_acc;
        if (lin_acc) begin
            mem_addr  = ptr_r;  // see [RL6]
            mem_ram   = 1'b0;
            mem_wide  = (sel == REG_WORD_AUTOINC);  // see [RL8]
            mem_wr    = reg_wr;
            mem_rd    = reg_rd;
            // Wide data goes out big-endian, a byte sits in the upper lane.
            mem_wdata = mem_wide ? reg_wdata : {reg_wdata[7:0], 8'h00};  // see [RL11]
        end else begin
            mem_addr  = core_phys;  // see [RL1]
            mem_ram   = core_ram;  // see [RL4]
            mem_wide  = 1'b0;
            mem_wr    = core_wr;
            mem_rd    = core_rd;
            mem_wdata = {core_wdata, 8'h00};
        end
    end

    // =====================================================================
    // Register next state
    // =====================================================================
    always_comb begin
        page_nxt     = page_r;
        ptr_nxt      = ptr_r;
        rdata_nxt    = 16'h0000;
        mem_byte_nxt = 1'b0;
        mem_word_nxt = 1'b0;
        if (reg_wr) begin
            unique case (sel)
                REG_PAGE_SELECT:  page_nxt = reg_wdata[PAGE_W-1:0];  // see [RL2]
                REG_PTR_HIGH:     ptr_nxt[16] = reg_wdata[0];  // see [RL5]
                REG_PTR_MID:      ptr_nxt[15:8] = reg_wdata[7:0];  // see [RL5]
                REG_PTR_LOW:      ptr_nxt[7:0] = reg_wdata[7:0];  // see [RL5]
                REG_OFFSET_ADD:   ptr_nxt = ptr_sum;  // see [RL9]
                REG_BYTE_DATA,
                REG_BYTE_AUTOINC,
                REG_WORD_AUTOINC: ptr_nxt = ptr_r;
            endcase
        end
        if (step_acc) begin
            ptr_nxt = ptr_sum;  // see [RL7] see [RL8] see [RL12]
        end
        if (reg_rd) begin
            unique case (sel)
                REG_PAGE_SELECT:  rdata_nxt = {13'h0, page_r};  // see [RL2]
                REG_PTR_HIGH:     rdata_nxt = {15'h0, ptr_r[16]};  // see [RL5]
                REG_PTR_MID:      rdata_nxt = {8'h00, ptr_r[15:8]};
                REG_PTR_LOW:      rdata_nxt = {8'h00, ptr_r[7:0]};
                REG_BYTE_DATA,
                REG_BYTE_AUTOINC: mem_byte_nxt = 1'b1;  // see [RL6]
                REG_WORD_AUTOINC: mem_word_nxt = 1'b1;
                REG_OFFSET_ADD:   rdata_nxt = 16'h0000;
            endcase
        end
    end

    // Page select comes up on page two so pages one to three run contiguous.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            page_r     <= PAGE_RESET[PAGE_W-1:0];  // see [RL10]
            ptr_r      <= PTR_RESET;
            rdata_r    <= 16'h0000;
            mem_byte_r <= 1'b0;
            mem_word_r <= 1'b0;
        end else begin
            page_r     <= page_nxt;
            ptr_r      <= ptr_nxt;
            rdata_r    <= rdata_nxt;
            mem_byte_r <= mem_byte_nxt;
            mem_word_r <= mem_word_nxt;
        end
    end

    // =====================================================================
    // Read data
    // =====================================================================
    // Memory data passes straight through: registering it would push the
    // answer past the single cycle that the register port allows.
    always_comb begin
        if (mem_word_r) begin
            reg_rdata = mem_rdata;  // see [RL11]
        end else if (mem_byte_r) begin
            reg_rdata = {8'h00, mem_rdata[15:8]};  // see [RL6]
        end else begin
            reg_rdata = rdata_r;
        end
        core_rdata = mem_rdata[15:8];
    end

    // =====================================================================
    // Checks
    // =====================================================================
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence word_read_req;
        reg_rd && sel == REG_WORD_AUTOINC;
    endsequence

    sequence word_read_out;
        mem_rd && mem_wide && mem_addr == ptr_r ##1 reg_rdata == mem_rdata;
    endsequence

    sequence byte_read_out;
        mem_rd && !mem_wide && mem_addr == ptr_r ##1 reg_rdata == {8'h00, mem_rdata[15:8]};
    endsequence

    page_reset_a: assert property ($rose(rstn) |-> page_r == PAGE_RESET[2:0])  // see [RL10]
        else $error("page select not at reset page");

    page_write_a: assert property (  // see [RL2]
        reg_wr && sel == REG_PAGE_SELECT |=> page_r == $past(reg_wdata[2:0]))
        else $error("page select write not taken");

    // A page change without a write would silently move the window.
    page_hold_a: assert property (  // see [RL2]
        !(reg_wr && sel == REG_PAGE_SELECT) |=> $stable(page_r))
        else $error("page select changed without a write");

    window_map_a: assert property (  // see [RL1]
        !lin_acc && core_addr[15:14] == REGION_WIN && (core_rd || core_wr)
        |-> mem_addr == {page_r, core_addr[13:0]} && !mem_ram)
        else $error("window access did not reach selected page");

    fixed_map_a: assert property (  // see [RL4]
        !lin_acc && (core_rd || core_wr) |->
        (core_addr[15:14] == REGION_RAM) == mem_ram &&
        (core_addr[15:14] != REGION_LOW || mem_addr[16:14] == LOW_PAGE) &&
        (core_addr[15:14] != REGION_HIGH || mem_addr[16:14] == HIGH_PAGE))
        else $error("unpaged region mapped wrongly");

    ptr_high_a: assert property (  // see [RL5]
        reg_wr && sel == REG_PTR_HIGH |=> ptr_r[16] == $past(reg_wdata[0]) &&
        ptr_r[15:0] == $past(ptr_r[15:0]))
        else $error("pointer high byte write wrong");

    byte_data_a: assert property (  // see [RL6]
        reg_rd && sel == REG_BYTE_DATA |-> byte_read_out and ##1 $stable(ptr_r))
        else $error("byte data read wrong or pointer moved");

    byte_inc_a: assert property (  // see [RL7]
        step_acc && sel == REG_BYTE_AUTOINC |=> ptr_r == $past(ptr_r) + 17'h00001)
        else $error("byte autoincrement step wrong");

    word_inc_a: assert property (  // see [RL8]
        step_acc && sel == REG_WORD_AUTOINC |=> ptr_r == $past(ptr_r) + 17'h00002)
        else $error("word autoincrement step wrong");

    word_order_a: assert property (word_read_req |-> word_read_out)  // see [RL11]
        else $error("word read not big-endian from pointer");

    offset_add_a: assert property (  // see [RL9]
        reg_wr && sel == REG_OFFSET_ADD |=>
        ptr_r == $past(ptr_r) + {{9{$past(reg_wdata[7])}}, $past(reg_wdata[7:0])})
        else $error("offset add wrong");

    // Both step sizes must wrap past the top of memory, not stick there.
    ptr_wrap_a: assert property (  // see [RL12]
        step_acc && ptr_r == 17'h1ffff |=> ptr_r == {16'h0000, $past(sel == REG_WORD_AUTOINC)})
        else $error("pointer did not wrap");

endmodule

// >>> dv/mem_model.sv
// Behavioural RAM and flash that answer the paging unit's physical bus.
`timescale 1ns/1ps
module mem_model
    import mmu_pkg::*;
(
    // Clock
    input  wire logic              clk,
    // Request
    input  wire logic [PHYS_W-1:0] mem_addr,
    input  wire logic              mem_ram,
    input  wire logic              mem_wide,
    input  wire logic              mem_wr,
    input  wire logic              mem_rd,
    input  wire logic [15:0]       mem_wdata,
    // Answer
    output logic      [15:0]       mem_rdata
);
    logic [7:0]        ram [0:16383];
    logic [7:0]        fl [0:131071];
    logic [PHYS_W-1:0] nxt;

    // Each flash byte gets a value from its address; bytes 0x0ffff and 0x10000 come out equal.
    initial begin
        mem_rdata = 16'h0;
        for (int i = 0; i < 131072; i++) begin
            fl[i] = 8'(i) ^ 8'(i >> 9) ^ 8'h5a;
        end
    end

    // The second byte wraps over 17 bits like the pointer does.
    assign nxt = mem_addr + 17'h1;

    // Data stand only in the cycle after a read; otherwise the lanes toggle.
    always @(posedge clk) begin
        if (mem_wr && mem_ram) begin
            ram[mem_addr[13:0]] <= mem_wdata[15:8];
        end
        if (mem_wr && !mem_ram) begin
            fl[mem_addr] <= mem_wdata[15:8];
            if (mem_wide) begin
                fl[nxt] <= mem_wdata[7:0];
            end
        end
        if (mem_rd) begin
            mem_rdata <= mem_ram ? {ram[mem_addr[13:0]], 8'h00} : {fl[mem_addr], fl[nxt]};
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

// >>> dv/tb_memory_paging_unit.sv
// Self-checking testbench for the memory paging unit.
`timescale 1ns/1ps
module tb_memory_paging_unit import mmu_pkg::*; ;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [2:0]  reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [15:0] core_addr = 16'h0;
    logic [7:0]  core_wdata = 8'h0;
    logic        core_wr = 1'b0;
    logic        core_rd = 1'b0;
    logic        core_ready;
    logic [7:0]  core_rdata;
    logic [16:0] mem_addr;
    logic        mem_ram, mem_wide, mem_wr, mem_rd;
    logic [15:0] mem_wdata, mem_rdata;
    logic [31:0] seed = 32'h27ab;
    logic [31:0] r;
    logic [16:0] ptr;
    logic [13:0] off;
    int          failures = 0;
    int          comparisons = 0;

    memory_paging_unit uut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .core_addr(core_addr), .core_wdata(core_wdata), .core_wr(core_wr),
        .core_rd(core_rd), .core_ready(core_ready), .core_rdata(core_rdata),
        .mem_addr(mem_addr), .mem_ram(mem_ram), .mem_wide(mem_wide), .mem_wr(mem_wr),
        .mem_rd(mem_rd), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    mem_model mdl (.clk(clk), .mem_addr(mem_addr), .mem_ram(mem_ram),
        .mem_wide(mem_wide), .mem_wr(mem_wr), .mem_rd(mem_rd),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

    // =======================================
    // Helpers
    // =======================================
    always #12.5 clk = ~clk;

    // Xorshift keeps the random run repeatable.
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected pointer after a signed offset, wrapping over the whole memory.
    function automatic logic [16:0] offset_ptr(input logic [16:0] p, input logic [7:0] o);
        return p + {{9{o[7]}}, o};
    endfunction

    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One strobe cycle; read data are sampled in the cycle after it.
    task automatic reg_op(input logic wr, input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= wr;
        reg_rd <= !wr;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
    endtask

    task automatic core_op(input logic wr, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        core_addr <= a;
        core_wdata <= d;
        core_wr <= wr;
        core_rd <= !wr;
        @(posedge clk);
        core_wr <= 1'b0;
        core_rd <= 1'b0;
        #1;
    endtask

    task automatic set_ptr(input logic [16:0] p);
        reg_op(1'b1, REG_PTR_HIGH, {15'h0, p[16]});
        reg_op(1'b1, REG_PTR_MID, {8'h0, p[15:8]});
        reg_op(1'b1, REG_PTR_LOW, {8'h0, p[7:0]});
    endtask

    task automatic get_ptr(input logic [16:0] p);
        logic [15:0] h;
        logic [15:0] m;
        reg_op(1'b0, REG_PTR_HIGH, 16'h0);
        h = reg_rdata;
        reg_op(1'b0, REG_PTR_MID, 16'h0);
        m = reg_rdata;
        reg_op(1'b0, REG_PTR_LOW, 16'h0);
        check({h[0], m[7:0], reg_rdata[7:0]}, p);
    endtask

    task automatic finish_test();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // A whole run takes under 500 cycles of the 20000 that fit here, so this limit is generous.
    initial begin
        #500000;
        failures++;
        finish_test();
    end

    // =======================================
    // Scenarios
    // =======================================
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        reg_op(1'b0, REG_PAGE_SELECT, 16'h0);
        check(reg_rdata, 17'h2);
        // The offset register reads as zero even right after a non-zero read.
        reg_op(1'b0, REG_OFFSET_ADD, 16'h0);
        check(reg_rdata, 17'h0);
        get_ptr(17'h0);
        // Every page through the window, with junk in the unused page bits.
        for (int p = 0; p < 8; p++) begin
            r = rnd();
            reg_op(1'b1, REG_PAGE_SELECT, {8'h0, r[7:3], 3'(p)});
            reg_op(1'b0, REG_PAGE_SELECT, 16'h0);
            check(reg_rdata, 17'(p));
            core_op(1'b0, {2'b10, r[21:8]}, 8'h0);
            check(core_rdata, mdl.fl[{3'(p), r[21:8]}]);
        end
        // Unpaged regions: low flash, high flash and RAM.
        off = r[13:0];
        core_op(1'b0, {2'b01, off}, 8'h0);
        check(core_rdata, mdl.fl[{3'h1, off}]);
        core_op(1'b0, {2'b11, off}, 8'h0);
        check(core_rdata, mdl.fl[{3'h3, off}]);
        core_op(1'b1, {2'b00, off}, 8'h3c);
        core_op(1'b0, {2'b00, off}, 8'h0);
        check(core_rdata, 17'h3c);
        // Linear reads across the carry into the top pointer bit.
        set_ptr(17'h0ffff);
        reg_op(1'b0, REG_BYTE_DATA, 16'h0);
        check(reg_rdata, mdl.fl[17'h0ffff]);
        get_ptr(17'h0ffff);
        reg_op(1'b0, REG_BYTE_AUTOINC, 16'h0);
        check(reg_rdata, mdl.fl[17'h0ffff]);
        get_ptr(17'h10000);
        reg_op(1'b0, REG_WORD_AUTOINC, 16'h0);
        check(reg_rdata, {mdl.fl[17'h10000], mdl.fl[17'h10001]});
        get_ptr(17'h10002);
        // Linear writes of each width.
        reg_op(1'b1, REG_WORD_AUTOINC, 16'ha55a);
        check({mdl.fl[17'h10002], mdl.fl[17'h10003]}, 17'ha55a);
        reg_op(1'b1, REG_BYTE_AUTOINC, 16'h00c3);
        check(mdl.fl[17'h10004], 17'hc3);
        reg_op(1'b1, REG_BYTE_DATA, 16'h0077);
        check(mdl.fl[17'h10005], 17'h77);
        get_ptr(17'h10005);
        // A word at the top of memory wraps to address zero.
        set_ptr(17'h1ffff);
        reg_op(1'b0, REG_WORD_AUTOINC, 16'h0);
        check(reg_rdata, {mdl.fl[17'h1ffff], mdl.fl[17'h0]});
        get_ptr(17'h00001);
        // A processor read colliding with a linear access must lose.
        @(posedge clk);
        reg_addr <= REG_BYTE_AUTOINC;
        reg_rd <= 1'b1;
        core_addr <= 16'h4000;
        core_rd <= 1'b1;
        #1;
        check(core_ready, 17'h0);
        check(mem_addr, 17'h00001);
        @(posedge clk);
        reg_rd <= 1'b0;
        core_rd <= 1'b0;
        #1;
        check(reg_rdata, mdl.fl[17'h00001]);
        check(core_ready, 17'h1);
        // Signed offsets, the first one wrapping below zero.
        ptr = 17'h00010;
        set_ptr(ptr);
        for (int i = 0; i < 40; i++) begin
            r = rnd();
            if (i == 0) begin
                r[7:0] = 8'h80;
            end
            reg_op(1'b1, REG_OFFSET_ADD, {8'h0, r[7:0]});
            ptr = offset_ptr(ptr, r[7:0]);
            get_ptr(ptr);
        end
        finish_test();
    end
endmodule
